// ==== hdl/can_xcvr_cfg.svh ====
/*
 * Constants of the transceiver mode and supply controller: times, counts,
 * register offsets, field positions, mode status codes and patterns.
 * Assumes a 10 MHz system clock and a 32-bit APB register bus.
 */
// How it works
// - regulator turns on by itself on bus activity or host enable
// - regulator health shown in diagnosis and interrupt registers
// - manual supply-on bit powers regulator independently of mode control
// - start timeout or short disables regulator, clears good, sets tx-off, clears manual
// - restart on tx-off cleared in Active, wake, manual set, Active entry
// - four modes, current one in two-bit diagnosis status field
// - Active needs request bit and chip run state; supply forced on
// - transmitter-disable bit keeps transmitter off, listen-only
// - leaving Active stops transmitter, watches for wake, autonomous termination
// - On-line keeps transmitter off; receive line goes low on wake
// - bus stuck at one level for off-line time enters Off-line
// - On-line Listen ignores bus except global wake, or conventional wake while partial networking enable is clear; receive line high
// - off-line time selectable, extended after entry from Off-line
// - termination mid-supply when on, ground in Off-line, floating on overload
// - conventional wake needs dominant, recessive, dominant, recessive
// - partial networking enable makes Listen use global wake frames
// - global wake needs first frame then second frame within timeout
// - after leaving Off-line for Listen second frame alone wakes until timeout
// - nine failure classes detected separately
// - each class in failure field; any change raises enabled interrupt
// - transmit line dominant too long disables transmitter until recovery and a bus edge or tx-off clear
// - receive line recessive under dominant bus disables transmitter
`ifndef CAN_XCVR_CFG_SVH
`define CAN_XCVR_CFG_SVH

// timing, in microseconds, and clock rate
`define CLK_MHZ        10
`define SUP_CLT_US     2000
`define OFFL_SHORT_US  50000
`define OFFL_LONG_US   200000
`define OFFL_EXT_US    500000
`define GWU_TMO_US     115000
`define TXD_DOM_US     1000
`define BUS_DOM_US     1000
`define RXD_CLAMP_US   10

// register byte offsets
`define OFF_CTRL 8'h00
`define OFF_DIAG 8'h04
`define OFF_INTS 8'h08
`define OFF_INTE 8'h0C

// control fields
`define CTRL_REQ  0
`define CTRL_TXD  1
`define CTRL_MAN  2
`define CTRL_OTS  3
`define CTRL_PNE  4
`define CTRL_W    5

// diagnosis fields
`define DIAG_MODE 0
`define DIAG_GOOD 2
`define DIAG_FAIL 3

// interrupt fields
`define INT_SUP  0
`define INT_FAIL 1
`define INT_W    2

// mode status codes
`define MD_OFFLINE 2'h0
`define MD_LISTEN  2'h1
`define MD_ONLINE  2'h2
`define MD_ACTIVE  2'h3

// global wake data: six common bytes, then the closing byte
`define GWU_HEAD  48'hC6EEEEEEEEEE
`define GWU_FIRST 8'hEF
`define GWU_WAKE  8'h37
`define GWU_DLC   4'h7

`endif

// ==== hdl/can_xcvr_pkg.sv ====
/*
 * Types shared by the transceiver controller.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package can_xcvr_pkg;
    // transceiver operating modes
    typedef enum logic [1:0] {
        MODE_OFFLINE,
        MODE_LISTEN,
        MODE_ONLINE,
        MODE_ACTIVE
    } mode_t;
endpackage

// ==== hdl/can_xcvr_ctrl.sv ====
/*
 * Transceiver mode, supply regulator and failure controller with an
 * APB register slave. Assumes all inputs synchronous to clk_sys, analog
 * short detectors and a frame decoder presenting one pulse per frame.
 */
`timescale 1ns/1ps
`include "can_xcvr_cfg.svh"

module can_xcvr_ctrl #(
    parameter int CW        = 24,
    parameter int SUP_CLT   = `SUP_CLT_US * `CLK_MHZ,
    parameter int OFFL_SHRT = `OFFL_SHORT_US * `CLK_MHZ,
    parameter int OFFL_LONG = `OFFL_LONG_US * `CLK_MHZ,
    parameter int OFFL_EXT  = `OFFL_EXT_US * `CLK_MHZ,
    parameter int GWU_TMO   = `GWU_TMO_US * `CLK_MHZ,
    parameter int TXD_DOM   = `TXD_DOM_US * `CLK_MHZ,
    parameter int BUS_DOM   = `BUS_DOM_US * `CLK_MHZ,
    parameter int RXD_CLAMP = `RXD_CLAMP_US * `CLK_MHZ
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        srst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // chip and bus sense
    input  wire logic        chip_run,
    input  wire logic        bus_dominant,
    input  wire logic        transmit_data_line,
    input  wire logic        rx_line_sense,
    input  wire logic [4:0]  line_fault,
    // regulator
    input  wire logic        supply_ok,
    input  wire logic        supply_short,
    output logic             transceiver_supply_regulator,
    // frame decoder
    input  wire logic        frame_done,
    input  wire logic [3:0]  frame_dlc,
    input  wire logic [55:0] frame_data,
    // transceiver outputs
    output logic             tx_enable,
    output logic             receive_data_line,
    output logic             term_mid,
    output logic             term_gnd,
    output logic             wake_event,
    output logic             irq
);

    // ****************************************
    // functions
    // ****************************************

    // global wake frame check, any identifier
    function automatic logic gwu_match(input logic [3:0] dlc,
                                       input logic [55:0] d,
                                       input logic [7:0] last);
        gwu_match = (dlc == `GWU_DLC) && (d == {`GWU_HEAD, last});
    endfunction

    // ****************************************
    // state
    // ****************************************

    can_xcvr_pkg::mode_t mode_q;
    can_xcvr_pkg::mode_t mode_d;
    logic [`CTRL_W-1:0]  ctrl_q;
    logic [`INT_W-1:0]   ints_q;
    logic [`INT_W-1:0]   inte_q;
    logic [8:0]          fail_q;
    logic                failed_q;
    logic                good_q;
    logic                wake_q;
    logic                ext_q;
    logic                bus_q;
    logic [1:0]          phase_q;
    logic                gwu_arm_q;
    logic                gwu_first_q;
    logic [CW-1:0]       clt_cnt_q;
    logic [CW-1:0]       lvl_cnt_q;
    logic [CW-1:0]       gwu_cnt_q;
    logic [CW-1:0]       txd_cnt_q;
    logic [CW-1:0]       rxr_cnt_q;
    logic [CW-1:0]       rxd_cnt_q;
    logic                txd_clamp_q;
    logic                rxd_clamp_q;

    logic                wr;
    logic                rd_take;
    logic                bus_edge;
    logic                run_req;
    logic                txd_fall;
    logic                man_set;
    logic                conv_wake;
    logic                gwu_wake;
    logic                wake_now;
    logic                sup_fail;
    logic                restart;
    logic                demand;
    logic [CW-1:0]       offl_lim;
    logic [8:0]          fail_d;

    // ****************************************
    // apb slave
    // ****************************************

    // one wait state, so every answer comes from a flop
    assign rd_take = psel & penable & ~pready;
    assign wr      = psel & penable & pready & pwrite;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= rd_take;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (rd_take) begin
                if (paddr == `OFF_CTRL) begin
                    prdata[`CTRL_W-1:0] <= ctrl_q;
                end else if (paddr == `OFF_DIAG) begin
                    prdata[`DIAG_MODE +: 2] <= mode_q;
                    prdata[`DIAG_GOOD]      <= good_q;
                    prdata[`DIAG_FAIL +: 9] <= fail_q;
                end else if (paddr == `OFF_INTS) begin
                    prdata[`INT_W-1:0] <= ints_q;
                end else if (paddr == `OFF_INTE) begin
                    prdata[`INT_W-1:0] <= inte_q;
                end else begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

    // ****************************************
    // control register
    // ****************************************

    assign txd_fall = wr && (paddr == `OFF_CTRL) && ctrl_q[`CTRL_TXD]
                      && !pwdata[`CTRL_TXD];
    assign man_set  = wr && (paddr == `OFF_CTRL) && !ctrl_q[`CTRL_MAN]
                      && pwdata[`CTRL_MAN];

    // overload forces tx-off and drops manual; hardware set beats write
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ctrl_q <= '0;
        end else begin
            if (wr && paddr == `OFF_CTRL) begin
                ctrl_q <= pwdata[`CTRL_W-1:0];
            end
            if (sup_fail) begin
                ctrl_q[`CTRL_TXD] <= 1'b1;
                ctrl_q[`CTRL_MAN] <= 1'b0;
            end
        end
    end

    // interrupt enable
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            inte_q <= '0;
        end else if (wr && paddr == `OFF_INTE) begin
            inte_q <= pwdata[`INT_W-1:0];
        end
    end

    // sticky events, write one to clear, a new event wins
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ints_q <= '0;
        end else begin
            if (wr && paddr == `OFF_INTS) begin
                ints_q <= ints_q & ~pwdata[`INT_W-1:0];
            end
            if (sup_fail) begin
                ints_q[`INT_SUP] <= 1'b1;
            end
            if (fail_d != fail_q) begin
                ints_q[`INT_FAIL] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(ints_q & inte_q);
        end
    end

    // ****************************************
    // bus activity and conventional wake
    // ****************************************

    assign bus_edge = bus_dominant != bus_q;
    assign run_req  = ctrl_q[`CTRL_REQ] & chip_run;

    // level duration, restarted at each edge
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            bus_q     <= 1'b0;
            lvl_cnt_q <= '0;
        end else begin
            bus_q <= bus_dominant;
            if (bus_edge) begin
                lvl_cnt_q <= '0;
            end else if (lvl_cnt_q != {CW{1'b1}}) begin
                lvl_cnt_q <= lvl_cnt_q + 1'b1;
            end
        end
    end

    // counts dominant, recessive, dominant phases; next recessive wakes
    always_ff @(posedge clk_sys) begin
        if (srst || mode_q == can_xcvr_pkg::MODE_ACTIVE) begin
            phase_q <= 2'h0;
        end else if (bus_edge && (phase_q[0] != bus_dominant)) begin
            phase_q <= phase_q + 2'h1;
        end
    end

    assign conv_wake = (phase_q == 2'h3) && bus_edge && !bus_dominant
        && (mode_q == can_xcvr_pkg::MODE_ONLINE
            || (mode_q == can_xcvr_pkg::MODE_LISTEN && !ctrl_q[`CTRL_PNE]));

    // ****************************************
    // global wake filter
    // ****************************************

    assign gwu_wake = mode_q == can_xcvr_pkg::MODE_LISTEN
        && ctrl_q[`CTRL_PNE] && frame_done && gwu_arm_q
        && gwu_match(frame_dlc, frame_data, `GWU_WAKE);

    // first frame or the step from off-line to listen arms a window of the timeout
    always_ff @(posedge clk_sys) begin
        if (srst || mode_q != can_xcvr_pkg::MODE_LISTEN) begin
            gwu_arm_q   <= 1'b0;
            gwu_first_q <= 1'b0;
            gwu_cnt_q   <= '0;
            if (!srst && mode_q == can_xcvr_pkg::MODE_OFFLINE
                && mode_d == can_xcvr_pkg::MODE_LISTEN) begin
                gwu_arm_q <= 1'b1;
            end
        end else if (ctrl_q[`CTRL_PNE] && frame_done
                     && gwu_match(frame_dlc, frame_data, `GWU_FIRST)) begin
            gwu_arm_q   <= 1'b1;
            gwu_first_q <= 1'b1;
            gwu_cnt_q   <= '0;
        end else if (gwu_arm_q) begin
            if (gwu_cnt_q >= CW'(GWU_TMO - 1)) begin
                gwu_arm_q   <= 1'b0;
                gwu_first_q <= 1'b0;
            end else begin
                gwu_cnt_q <= gwu_cnt_q + 1'b1;
            end
        end
    end

    assign wake_now = conv_wake | gwu_wake;

    // ****************************************
    // mode controller
    // ****************************************

    always_comb begin
        offl_lim = ext_q ? CW'(OFFL_EXT)
                 : (ctrl_q[`CTRL_OTS] ? CW'(OFFL_LONG) : CW'(OFFL_SHRT));
    end

    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            can_xcvr_pkg::MODE_ACTIVE: begin
                if (!run_req) begin
                    mode_d = ctrl_q[`CTRL_PNE] ? can_xcvr_pkg::MODE_LISTEN
                                               : can_xcvr_pkg::MODE_ONLINE;
                end
            end
            can_xcvr_pkg::MODE_ONLINE,
            can_xcvr_pkg::MODE_LISTEN: begin
                if (run_req) begin
                    mode_d = can_xcvr_pkg::MODE_ACTIVE;
                end else if (lvl_cnt_q >= offl_lim - 1'b1) begin
                    mode_d = can_xcvr_pkg::MODE_OFFLINE;
                end
            end
            can_xcvr_pkg::MODE_OFFLINE: begin
                if (run_req) begin
                    mode_d = can_xcvr_pkg::MODE_ACTIVE;
                end else if (bus_edge) begin
                    mode_d = ctrl_q[`CTRL_PNE] ? can_xcvr_pkg::MODE_LISTEN
                                               : can_xcvr_pkg::MODE_ONLINE;
                end
            end
            default: begin
                mode_d = can_xcvr_pkg::MODE_OFFLINE;
            end
        endcase
    end

    // mode register; extension holds until the first bus edge
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            mode_q <= can_xcvr_pkg::MODE_OFFLINE;
            ext_q  <= 1'b0;
        end else begin
            mode_q <= mode_d;
            if (mode_q == can_xcvr_pkg::MODE_OFFLINE
                && mode_d != can_xcvr_pkg::MODE_OFFLINE) begin
                ext_q <= 1'b1;
            end else if (bus_edge || mode_d == can_xcvr_pkg::MODE_OFFLINE) begin
                ext_q <= 1'b0;
            end
        end
    end

    // wake status held until Active is reached
    always_ff @(posedge clk_sys) begin
        if (srst || mode_q == can_xcvr_pkg::MODE_ACTIVE) begin
            wake_q     <= 1'b0;
            wake_event <= 1'b0;
        end else begin
            wake_event <= wake_now;
            if (wake_now) begin
                wake_q <= 1'b1;
            end
        end
    end

    // ****************************************
    // supply regulator
    // ****************************************

    assign demand = (mode_q != can_xcvr_pkg::MODE_OFFLINE)
                  | ctrl_q[`CTRL_MAN];
    assign sup_fail = transceiver_supply_regulator && !failed_q
        && ((!supply_ok && clt_cnt_q >= CW'(SUP_CLT - 1))
            || supply_short);
    assign restart = (txd_fall && mode_q == can_xcvr_pkg::MODE_ACTIVE)
        || wake_now || man_set
        || (mode_d == can_xcvr_pkg::MODE_ACTIVE
            && mode_q != can_xcvr_pkg::MODE_ACTIVE);

    // start timer runs only while on and not yet up
    always_ff @(posedge clk_sys) begin
        if (srst || !transceiver_supply_regulator || supply_ok) begin
            clt_cnt_q <= '0;
        end else if (clt_cnt_q != {CW{1'b1}}) begin
            clt_cnt_q <= clt_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            failed_q <= 1'b0;
        end else if (sup_fail) begin
            failed_q <= 1'b1;
        end else if (restart) begin
            failed_q <= 1'b0;
        end
    end

    // Active entry forces the supply on in the same edge
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            transceiver_supply_regulator <= 1'b0;
            good_q                       <= 1'b0;
        end else begin
            transceiver_supply_regulator <= (demand || restart) && !sup_fail
                                            && (!failed_q || restart);
            good_q <= transceiver_supply_regulator && supply_ok
                      && !failed_q && !sup_fail;
        end
    end

    // ****************************************
    // clamp and failure detection
    // ****************************************

    // transmit line low too long; cleared on recovery plus activity
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            txd_cnt_q   <= '0;
            txd_clamp_q <= 1'b0;
        end else begin
            txd_cnt_q <= transmit_data_line ? '0
                       : (txd_cnt_q >= CW'(TXD_DOM) ? txd_cnt_q
                                                    : txd_cnt_q + 1'b1);
            if (!transmit_data_line && txd_cnt_q >= CW'(TXD_DOM - 1)) begin
                txd_clamp_q <= 1'b1;
            end else if (transmit_data_line && (bus_edge || txd_fall)) begin
                txd_clamp_q <= 1'b0;
            end
        end
    end

    // receive line recessive while bus dominant; or stuck dominant
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rxr_cnt_q   <= '0;
            rxd_cnt_q   <= '0;
            rxd_clamp_q <= 1'b0;
        end else begin
            rxr_cnt_q <= !(rx_line_sense && bus_dominant) ? '0
                       : (rxr_cnt_q >= CW'(RXD_CLAMP) ? rxr_cnt_q
                                                      : rxr_cnt_q + 1'b1);
            rxd_cnt_q <= !(!rx_line_sense && !bus_dominant) ? '0
                       : (rxd_cnt_q >= CW'(RXD_CLAMP) ? rxd_cnt_q
                                                      : rxd_cnt_q + 1'b1);
            if (rxr_cnt_q >= CW'(RXD_CLAMP - 1) && rx_line_sense
                && bus_dominant) begin
                rxd_clamp_q <= 1'b1;
            end else if (!rx_line_sense || txd_fall) begin
                rxd_clamp_q <= 1'b0;
            end
        end
    end

    // nine classes: five analog shorts then four timed clamps
    always_comb begin
        fail_d      = '0;
        fail_d[4:0] = line_fault;
        fail_d[5]   = bus_dominant && lvl_cnt_q >= CW'(BUS_DOM - 1);
        fail_d[6]   = txd_clamp_q;
        fail_d[7]   = rxd_clamp_q;
        fail_d[8]   = rxd_cnt_q >= CW'(RXD_CLAMP);
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            fail_q <= '0;
        end else begin
            fail_q <= fail_d;
        end
    end

    // ****************************************
    // transceiver outputs
    // ****************************************

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            tx_enable         <= 1'b0;
            receive_data_line <= 1'b1;
            term_mid          <= 1'b0;
            term_gnd          <= 1'b0;
        end else begin
            tx_enable <= mode_q == can_xcvr_pkg::MODE_ACTIVE
                      && !ctrl_q[`CTRL_TXD]
                      && !txd_clamp_q && !rxd_clamp_q
                      && good_q;
            case (mode_q)
                can_xcvr_pkg::MODE_ACTIVE: begin
                    receive_data_line <= !bus_dominant;
                end
                can_xcvr_pkg::MODE_LISTEN: begin
                    receive_data_line <= 1'b1;
                end
                default: begin
                    receive_data_line <= !wake_q;
                end
            endcase
            // floating when the supply is shut by overload
            term_mid <= !failed_q && mode_q != can_xcvr_pkg::MODE_OFFLINE;
            term_gnd <= !failed_q && mode_q == can_xcvr_pkg::MODE_OFFLINE;
        end
    end

endmodule

// ==== testbench/can_xcvr_properties.sv ====
/* port checker of the transceiver controller.
   assumes binding into each instance. */
`timescale 1ns/1ps
module can_xcvr_properties #(parameter int TXD_DOM = 10) (
    // clock, reset and apb
    input wire logic        clk_sys,
    input wire logic        srst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // transceiver side
    input wire logic        chip_run,
    input wire logic        transmit_data_line,
    input wire logic        supply_short,
    input wire logic        transceiver_supply_regulator,
    input wire logic        tx_enable,
    input wire logic        term_mid,
    input wire logic        term_gnd,
    input wire logic        wake_event
);
    logic [15:0] dom_q;
    // saturating dominant count, never wraps
    always_ff @(posedge clk_sys) begin
        if (srst || transmit_data_line) dom_q <= 16'h0000;
        else if (dom_q != 16'hFFFF) dom_q <= dom_q + 16'h0001;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    sequence access_s; psel && penable && !pready; endsequence
    AST_ONE_WAIT: assert property (access_s |=> pready)
        else $error("late apb answer");
    AST_PREADY_PULSE: assert property (pready |=> !pready)
        else $error("long pready");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("stray pslverr");
    AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
        else $error("stray read data");
    AST_TERM_EXCL: assert property (!(term_mid && term_gnd))
        else $error("double termination");
    AST_SHORT_OFF: assert property (supply_short && transceiver_supply_regulator
        |-> ##[1:3] !transceiver_supply_regulator)
        else $error("regulator on in overload");
    AST_RUN_GATE: assert property (!chip_run [*3] |-> !tx_enable)
        else $error("tx on outside run");
    AST_TXD_CLAMP: assert property (dom_q > TXD_DOM + 3 |-> !tx_enable)
        else $error("tx on under clamp");
    AST_WAKE_PULSE: assert property (wake_event |=> !wake_event)
        else $error("long wake pulse");
endmodule
bind can_xcvr_ctrl can_xcvr_properties #(.TXD_DOM(TXD_DOM)) can_xcvr_properties_i (
    .clk_sys, .srst, .psel, .penable, .prdata, .pready, .pslverr, .chip_run,
    .transmit_data_line, .supply_short, .transceiver_supply_regulator, .tx_enable,
    .term_mid, .term_gnd, .wake_event);

// ==== testbench/can_bus_model.sv ====
/* bus wire and regulator model.
   assumes bench-driven knobs. */
`timescale 1ns/1ps
module can_bus_model (
    // transceiver side
    input  wire logic clk_sys,
    input  wire logic tx_enable,
    input  wire logic receive_data_line,
    input  wire logic transceiver_supply_regulator,
    // bench knobs
    input  wire logic host_txd,
    input  wire logic other_dom,
    input  wire logic supply_stuck,
    // sensed levels
    output logic      bus_dominant,
    output logic      rx_line_sense,
    output logic      supply_ok
);
    logic [1:0] ramp_q;
    // wired bus: any dominant driver wins
    assign bus_dominant  = (tx_enable && !host_txd) || other_dom;
    assign rx_line_sense = receive_data_line;
    // up two cycles after enable unless stuck
    always_ff @(posedge clk_sys) begin
        ramp_q <= transceiver_supply_regulator ? {ramp_q[0], 1'h1} : 2'h0;
    end
    assign supply_ok = ramp_q[1] && !supply_stuck;
endmodule

// ==== testbench/can_xcvr_ctrl_test.sv ====
/* self-checking apb bench of the controller.
   assumes the bus model and bound checker. */
`timescale 1ns/1ps
`include "can_xcvr_cfg.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module can_xcvr_ctrl_test;
    localparam logic [31:0] REQ = 32'h1 << `CTRL_REQ, TXB = 32'h1 << `CTRL_TXD;
    localparam logic [31:0] MAN = 32'h1 << `CTRL_MAN, GOOD = 32'h1 << `DIAG_GOOD;
    logic        clk_sys = 1'h0, srst, psel, penable, pwrite, chip_run, txd, odom, stuck;
    logic        shrt, pready, pslverr, reg_en, tx_en, rxd, t_mid, t_gnd, wake, irq, err;
    logic        bus_dom, rx_sense, sup_ok, fd;
    logic [3:0]  dl;
    logic [4:0]  lf;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [55:0] dd;
    int          errors, cmp_count;
    always #50 clk_sys = !clk_sys;
    can_bus_model can_bus_model_i (.clk_sys(clk_sys), .tx_enable(tx_en),
        .receive_data_line(rxd), .transceiver_supply_regulator(reg_en), .host_txd(txd),
        .other_dom(odom), .supply_stuck(stuck), .bus_dominant(bus_dom),
        .rx_line_sense(rx_sense), .supply_ok(sup_ok));
    can_xcvr_ctrl #(.SUP_CLT(30), .OFFL_SHRT(40), .OFFL_LONG(60), .OFFL_EXT(150),
        .GWU_TMO(50), .TXD_DOM(20), .BUS_DOM(60), .RXD_CLAMP(8)) can_xcvr_ctrl_i (
        .clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .chip_run(chip_run), .bus_dominant(bus_dom),
        .transmit_data_line(txd), .rx_line_sense(rx_sense), .line_fault(lf),
        .supply_ok(sup_ok), .supply_short(shrt), .transceiver_supply_regulator(reg_en),
        .frame_done(fd), .frame_dlc(dl), .frame_data(dd), .tx_enable(tx_en),
        .receive_data_line(rxd), .term_mid(t_mid), .term_gnd(t_gnd), .wake_event(wake),
        .irq(irq));
    task automatic tally_and_finish();
        $display("cmp %0d err %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // apb transfer, bounded wait
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk_sys);
        psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'h1;
        do begin @(posedge clk_sys); n++; end while (pready !== 1'h1 && n < 20);
        if (n == 20) begin errors++; tally_and_finish(); end
        else begin rd = prdata; err = pslverr; psel <= 1'h0; penable <= 1'h0; end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] m, e);
        apb(1'h0, a, 32'h0);
        `CHK(rd & m, e)
    endtask
    task automatic cyc(input int n); repeat (n) @(posedge clk_sys); endtask
    initial begin
        {psel, penable, pwrite, chip_run, odom, stuck, shrt, fd, lf, dl, dd} = 73'h0;
        paddr = 8'h00; pwdata = 32'h0; txd = 1'h1; srst = 1'h1; errors = 0; cmp_count = 0;
        cyc(16);
        srst <= 1'h0;
        rchk(`OFF_DIAG, 32'h3, `MD_OFFLINE);
        apb(1'h0, 8'h10, 32'h0); `CHK({err, rd}, 33'h100000000)
        $display("reset test done");
        // manual supply held low hits start timeout
        stuck <= 1'h1; apb(1'h1, `OFF_CTRL, MAN); cyc(3); `CHK(reg_en, 1'h1)
        cyc(35); `CHK(reg_en, 1'h0)
        rchk(`OFF_CTRL, MAN | TXB, TXB);
        rchk(`OFF_DIAG, GOOD, 32'h0);
        rchk(`OFF_INTS, 32'h1, 32'h1);
        stuck <= 1'h0; apb(1'h1, `OFF_INTS, 32'h3); rchk(`OFF_INTS, 32'h1, 32'h0);
        $display("supply test done");
        chip_run <= 1'h1; apb(1'h1, `OFF_CTRL, REQ); cyc(8);
        rchk(`OFF_DIAG, 32'h3 | GOOD, GOOD | `MD_ACTIVE);
        `CHK({reg_en, tx_en, t_mid, t_gnd}, 4'hE)
        apb(1'h1, `OFF_CTRL, REQ | TXB); cyc(3); `CHK(tx_en, 1'h0)
        apb(1'h1, `OFF_CTRL, REQ); cyc(3); `CHK(tx_en, 1'h1)
        txd <= 1'h0; cyc(26); `CHK(tx_en, 1'h0)
        txd <= 1'h1; rchk(`OFF_INTS, 32'h2, 32'h2);
        apb(1'h1, `OFF_CTRL, REQ | TXB); apb(1'h1, `OFF_CTRL, REQ); cyc(3);
        `CHK(tx_en, 1'h1)
        shrt <= 1'h1; cyc(5); `CHK({reg_en, t_mid, t_gnd}, 3'h0)
        shrt <= 1'h0; rchk(`OFF_CTRL, TXB, TXB);
        apb(1'h1, `OFF_CTRL, REQ); cyc(6); `CHK({reg_en, tx_en}, 2'h3)
        $display("active test done");
        odom <= 1'h1; cyc(2); {chip_run, odom} <= 2'h0; cyc(4); `CHK({tx_en, rxd}, 2'h1)
        rchk(`OFF_DIAG, 32'h3, `MD_ONLINE);
        repeat (2) begin odom <= 1'h1; cyc(5); odom <= 1'h0; cyc(5); end
        `CHK(rxd, 1'h0)
        cyc(48); rchk(`OFF_DIAG, 32'h3, `MD_OFFLINE);
        `CHK(t_gnd, 1'h1)
        apb(1'h1, `OFF_CTRL, 32'h1 << `CTRL_OTS); odom <= 1'h1; cyc(70);
        rchk(`OFF_DIAG, 32'h3, `MD_ONLINE);
        cyc(90); rchk(`OFF_DIAG, 32'h3, `MD_OFFLINE);
        apb(1'h1, `OFF_CTRL, 32'h1 << `CTRL_PNE); odom <= 1'h0; cyc(2);
        fd <= 1'h1; lf <= 5'h15; dl <= `GWU_DLC; dd <= {`GWU_HEAD, `GWU_WAKE}; cyc(1);
        fd <= 1'h0; cyc(1); `CHK(wake, 1'h1)
        rchk(`OFF_DIAG, 32'hFB, 32'hA9);
        `CHK(rxd, 1'h1)
        $display("bus mode test done");
        tally_and_finish();
    end
endmodule
